// *** src/charger_telemetry_irq_masks.sv ***
`timescale 1ns/1ps
`default_nettype none

module charger_telemetry_irq_masks (
  input  wire logic                             core_clk,
  input  wire logic                             rst_n,
  input  wire logic [7:0]                       regAddr,
  input  wire logic [7:0]                       regWrData,
  input  wire logic                             regWrite,
  input  wire logic                             regRead,
  output logic [7:0]                            regRdData,
  input  wire charger_telemetry_pkg::telemetry_s telemetry,
  input  wire charger_telemetry_pkg::status_s    statusIn,
  output logic [3:1]                            summaryFlags,
  output logic                                  hostIrq
);

  // Telemetry holding registers
  logic [15:0] bridgeInputPower;      // 10 mW units
  logic [15:0] fieldPowerEstimate;    // 10 mW units
  logic [15:0] receiverReportedPower; // As reported by receiver
  logic [7:0]  receiverBatteryPercent;
  logic [3:0]  indicatorCode;         // Upper nibble reads zero
  logic [7:0]  faultCode;
  logic [7:0]  faultParameter;

  // Software enables and sticky status
  logic [7:0]  summaryIrqEnable;
  logic [7:0]  receiverEventEnable;
  logic [7:0]  faultEventEnable;
  logic [7:0]  diagEventEnable;
  logic [7:0]  irqStatus;

  // Edge history
  logic        prevSendOk;
  logic        prevApiSendOk;

  // Next values
  logic [3:1]  next_summaryFlags;
  logic [7:0]  next_irqStatus;
  logic [7:0]  next_rdData;

  // Decode
  // Strobes are trusted to be one cycle wide; there is no bus error
  wire         wrSummaryEn = regWrite && (regAddr == charger_telemetry_pkg::ADDR_SUMMARY_EN);
  wire         wrRxEn      = regWrite && (regAddr == charger_telemetry_pkg::ADDR_RX_EVENT_EN);
  wire         wrFaultEn   = regWrite && (regAddr == charger_telemetry_pkg::ADDR_FAULT_EN);
  wire         wrDiagEn    = regWrite && (regAddr == charger_telemetry_pkg::ADDR_DIAG_EN);
  wire         wrIrqStatus = regWrite && (regAddr == charger_telemetry_pkg::ADDR_IRQ_STATUS);
  wire [7:0]   clearBits   = wrIrqStatus ? regWrData : 8'h00;

  // Group gating into summary flags
  assign next_summaryFlags[1] = |(statusIn.rxGroup & receiverEventEnable[5:0]);
  assign next_summaryFlags[2] = |(statusIn.faultGroup & faultEventEnable[1:0]);
  assign next_summaryFlags[3] = |(statusIn.diagGroup & diagEventEnable[1:0]);

  // Rising edges, one pulse each
  // A level already high at reset release counts as a rise
  wire         riseSendOk    = statusIn.sendOk && !prevSendOk;
  wire         riseApiSendOk = statusIn.apiSendOk && !prevApiSendOk;
  wire [3:1]   riseSummary   = next_summaryFlags & ~summaryFlags;
  wire [7:0]   events        = {2'b00, riseSendOk, riseApiSendOk, riseSummary, 1'b0};

  // Set wins over a clear in the same cycle
  // Zero bits in a clear write leave status untouched
  assign next_irqStatus = (irqStatus & ~clearBits) | events;

  // Read selection; unmapped offsets read zero
  // Bytes are not snapshotted, so software must allow for tearing
  assign next_rdData =
    (regAddr == charger_telemetry_pkg::ADDR_BRIDGE_POWER)      ? bridgeInputPower[7:0] :
    (regAddr == charger_telemetry_pkg::ADDR_BRIDGE_POWER + 8'h01) ? bridgeInputPower[15:8] :
    (regAddr == charger_telemetry_pkg::ADDR_FIELD_POWER)       ? fieldPowerEstimate[7:0] :
    (regAddr == charger_telemetry_pkg::ADDR_FIELD_POWER + 8'h01)  ? fieldPowerEstimate[15:8] :
    (regAddr == charger_telemetry_pkg::ADDR_RX_POWER)          ? receiverReportedPower[7:0] :
    (regAddr == charger_telemetry_pkg::ADDR_RX_POWER + 8'h01)     ? receiverReportedPower[15:8] :
    (regAddr == charger_telemetry_pkg::ADDR_BATTERY)           ? receiverBatteryPercent :
    (regAddr == charger_telemetry_pkg::ADDR_INDICATOR)         ? {4'h0, indicatorCode} :
    (regAddr == charger_telemetry_pkg::ADDR_FAULT_WORD)        ? faultCode :
    (regAddr == charger_telemetry_pkg::ADDR_FAULT_WORD + 8'h01)   ? faultParameter :
    (regAddr == charger_telemetry_pkg::ADDR_SUMMARY_EN)        ? summaryIrqEnable :
    (regAddr == charger_telemetry_pkg::ADDR_RX_EVENT_EN)       ? receiverEventEnable :
    (regAddr == charger_telemetry_pkg::ADDR_FAULT_EN)          ? faultEventEnable :
    (regAddr == charger_telemetry_pkg::ADDR_DIAG_EN)           ? diagEventEnable :
    (regAddr == charger_telemetry_pkg::ADDR_IRQ_STATUS)        ? irqStatus :
    8'h00;

  // Power values load on their pulses; no tear guard across bytes
  // No filtering here: the measurement side owns any averaging
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      bridgeInputPower      <= charger_telemetry_pkg::RESET_WORD;
      fieldPowerEstimate    <= charger_telemetry_pkg::RESET_WORD;
      receiverReportedPower <= charger_telemetry_pkg::RESET_WORD;
    end else begin
      if (telemetry.bridgeValid) begin
        bridgeInputPower <= telemetry.bridgePower;
      end
      if (telemetry.fieldValid) begin
        fieldPowerEstimate <= telemetry.fieldPower;
      end
      if (telemetry.rxValid) begin
        receiverReportedPower <= telemetry.rxPower;
      end
    end
  end

  // Battery, indicator and fault word
  // Reserved codes are stored as supplied, never filtered
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      receiverBatteryPercent <= charger_telemetry_pkg::RESET_BYTE;
      indicatorCode          <= charger_telemetry_pkg::IND_STANDBY;
      faultCode              <= charger_telemetry_pkg::FAULT_NONE;
      faultParameter         <= charger_telemetry_pkg::RESET_BYTE;
    end else begin
      if (telemetry.batteryValid) begin
        receiverBatteryPercent <= telemetry.battery;
      end
      if (telemetry.indicatorValid) begin
        indicatorCode <= telemetry.indicator;
      end
      // Code and parameter always move together
      if (telemetry.faultValid) begin
        faultCode      <= telemetry.faultCode;
        faultParameter <= telemetry.faultParameter;
      end
    end
  end

  // Enable registers; reserved bits never store
  // Masking at the write keeps the read path a plain mux
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      summaryIrqEnable    <= charger_telemetry_pkg::RESET_BYTE;
      receiverEventEnable <= charger_telemetry_pkg::RESET_BYTE;
      faultEventEnable    <= charger_telemetry_pkg::RESET_BYTE;
      diagEventEnable     <= charger_telemetry_pkg::RESET_BYTE;
    end else begin
      if (wrSummaryEn) begin
        summaryIrqEnable <= regWrData & charger_telemetry_pkg::WMASK_SUMMARY_EN;
      end
      if (wrRxEn) begin
        receiverEventEnable <= regWrData & charger_telemetry_pkg::WMASK_RX_EVENT_EN;
      end
      if (wrFaultEn) begin
        faultEventEnable <= regWrData & charger_telemetry_pkg::WMASK_FAULT_EN;
      end
      if (wrDiagEn) begin
        diagEventEnable <= regWrData & charger_telemetry_pkg::WMASK_DIAG_EN;
      end
    end
  end

  // Event history, sticky status, interrupt and read data
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      prevSendOk    <= 1'b0;
      prevApiSendOk <= 1'b0;
      summaryFlags  <= 3'h0;
      irqStatus     <= charger_telemetry_pkg::RESET_BYTE;
      hostIrq       <= 1'b0;
      regRdData     <= charger_telemetry_pkg::RESET_BYTE;
    end else begin
      prevSendOk    <= statusIn.sendOk;
      prevApiSendOk <= statusIn.apiSendOk;
      summaryFlags  <= next_summaryFlags;
      irqStatus     <= next_irqStatus;
      // Status always records; only enabled bits raise the line
      // An enable write reaches the line one cycle after it lands
      hostIrq       <= |(next_irqStatus & summaryIrqEnable);
      // Data stand only in the cycle after the read strobe
      regRdData     <= regRead ? next_rdData : 8'h00;
    end
  end

  // Checks
  a_field_power_read: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    regRead && regAddr == charger_telemetry_pkg::ADDR_FIELD_POWER
    |=> regRdData == $past(fieldPowerEstimate[7:0]))
    else $error("field power low byte read wrong");

  a_bridge_power_hold: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    telemetry.bridgeValid |=> bridgeInputPower == $past(telemetry.bridgePower))
    else $error("bridge power not loaded");

  a_rx_power_read: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    telemetry.rxValid ##1 (regRead && regAddr == charger_telemetry_pkg::ADDR_RX_POWER + 8'h01
      && !telemetry.rxValid)
    |=> regRdData == $past(telemetry.rxPower[15:8], 2))
    else $error("receiver power high byte wrong");

  a_battery_keep: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    !telemetry.batteryValid |=> $stable(receiverBatteryPercent))
    else $error("battery percent changed without load");

  a_indicator_upper: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    regRead && regAddr == charger_telemetry_pkg::ADDR_INDICATOR
    |=> regRdData[7:4] == 4'h0 && regRdData[3:0] == $past(indicatorCode))
    else $error("indicator read wrong");

  a_fault_pair: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    telemetry.faultValid |=> {faultParameter, faultCode}
      == $past({telemetry.faultParameter, telemetry.faultCode}))
    else $error("fault word not loaded as a pair");

  a_send_ok_irq: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    statusIn.sendOk && !prevSendOk && summaryIrqEnable[charger_telemetry_pkg::EVT_SEND_OK]
    |=> hostIrq)
    else $error("send-ok rise did not interrupt");

  a_api_irq_masked: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    summaryIrqEnable == 8'h10 && !irqStatus[charger_telemetry_pkg::EVT_API_SEND_OK]
      && !riseApiSendOk ##1 summaryIrqEnable == 8'h10
    |-> !hostIrq)
    else $error("interrupt without enabled event");

  a_group_irq: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    riseSummary[2] && summaryIrqEnable[charger_telemetry_pkg::EVT_FAULT]
    |=> irqStatus[charger_telemetry_pkg::EVT_FAULT] && hostIrq)
    else $error("summary rise did not interrupt");

  a_rx_gate: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    (statusIn.rxGroup & receiverEventEnable[5:0]) == 6'h00 |=> !summaryFlags[1])
    else $error("receiver summary set while gated off");

  a_fault_gate: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    |(statusIn.faultGroup & faultEventEnable[1:0]) |=> summaryFlags[2])
    else $error("fault summary not set");

  a_diag_gate: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    |(statusIn.diagGroup & diagEventEnable[1:0]) |=> summaryFlags[3])
    else $error("diag summary not set");

  a_set_beats_clear: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    wrIrqStatus && riseSendOk |=> irqStatus[charger_telemetry_pkg::EVT_SEND_OK])
    else $error("event lost on clear");

  // Reserved summary enable bits never hold a one
  a_summary_en_rsvd: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    (summaryIrqEnable & ~charger_telemetry_pkg::WMASK_SUMMARY_EN) == 8'h00)
    else $error("reserved enable bit stored");

  a_api_send_ok_irq: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    riseApiSendOk && summaryIrqEnable[charger_telemetry_pkg::EVT_API_SEND_OK] |=> hostIrq)
    else $error("api send-ok rise did not interrupt");

  a_fault_gate_off: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    (statusIn.faultGroup & faultEventEnable[1:0]) == 2'b00 |=> !summaryFlags[2])
    else $error("fault summary set while gated off");

  a_diag_gate_off: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    (statusIn.diagGroup & diagEventEnable[1:0]) == 2'b00 |=> !summaryFlags[3])
    else $error("diag summary set while gated off");

  a_irq_needs_status: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    hostIrq |-> irqStatus != 8'h00)
    else $error("interrupt with empty status");

  a_clear_drops_irq: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    wrIrqStatus && regWrData == 8'hFF && events == 8'h00 |=> !hostIrq)
    else $error("full clear left interrupt high");

  // Main scenarios worth seeing at least once
  c_api_send_ok_irq: cover property (@(posedge core_clk) disable iff (!rst_n)
    riseApiSendOk ##1 hostIrq);
  c_send_ok_irq: cover property (@(posedge core_clk) disable iff (!rst_n)
    riseSendOk ##1 hostIrq);
  c_irq_cleared: cover property (@(posedge core_clk) disable iff (!rst_n)
    hostIrq ##1 wrIrqStatus ##1 !hostIrq);
  c_foreign_fault: cover property (@(posedge core_clk) disable iff (!rst_n)
    telemetry.faultValid && telemetry.faultCode == charger_telemetry_pkg::FAULT_FOREIGN_OBJ);
  c_rx_summary: cover property (@(posedge core_clk) disable iff (!rst_n)
    riseSummary[1] ##1 hostIrq);

endmodule : charger_telemetry_irq_masks

`default_nettype wire

// *** src/charger_telemetry_pkg.sv ***
package charger_telemetry_pkg;

  // Register byte offsets, 16-bit values keep their low byte at the base
  localparam logic [7:0] ADDR_BRIDGE_POWER = 8'h56;
  localparam logic [7:0] ADDR_FIELD_POWER  = 8'h58;
  localparam logic [7:0] ADDR_RX_POWER     = 8'h5A;
  localparam logic [7:0] ADDR_BATTERY      = 8'h5C;
  localparam logic [7:0] ADDR_INDICATOR    = 8'h5D;
  localparam logic [7:0] ADDR_FAULT_WORD   = 8'h5E;
  localparam logic [7:0] ADDR_SUMMARY_EN   = 8'h78;
  localparam logic [7:0] ADDR_RX_EVENT_EN  = 8'h79;
  localparam logic [7:0] ADDR_FAULT_EN     = 8'h7A;
  localparam logic [7:0] ADDR_DIAG_EN      = 8'h7B;
  localparam logic [7:0] ADDR_IRQ_STATUS   = 8'h7C;

  // Writable bits; reserved bits stay zero
  localparam logic [7:0] WMASK_SUMMARY_EN  = 8'h3E;
  localparam logic [7:0] WMASK_RX_EVENT_EN = 8'h3F;
  localparam logic [7:0] WMASK_FAULT_EN    = 8'h03;
  localparam logic [7:0] WMASK_DIAG_EN     = 8'h03;

  // Reset values
  localparam logic [15:0] RESET_WORD = 16'h0000;
  localparam logic [7:0]  RESET_BYTE = 8'h00;

  // Event bit positions, shared by enable and sticky status
  localparam int EVT_SEND_OK     = 5;
  localparam int EVT_API_SEND_OK = 4;
  localparam int EVT_DIAG        = 3;
  localparam int EVT_FAULT       = 2;
  localparam int EVT_RX          = 1;

  // Power unit in milliwatts per count
  localparam int POWER_UNIT_MW = 10;

  // Indicator codes
  localparam logic [3:0] IND_STANDBY     = 4'h0;
  localparam logic [3:0] IND_TRANSFER    = 4'h1;
  localparam logic [3:0] IND_BATT_FULL   = 4'h2;
  localparam logic [3:0] IND_END_OK      = 4'h3;
  localparam logic [3:0] IND_RX_ERROR    = 4'h4;
  localparam logic [3:0] IND_TX_ERROR    = 4'h5;
  localparam logic [3:0] IND_FOREIGN_OBJ = 4'h6;

  // Fault codes
  localparam logic [7:0] FAULT_NONE         = 8'h00;
  localparam logic [7:0] FAULT_RESOURCES    = 8'h01;
  localparam logic [7:0] FAULT_PKT_TIMING   = 8'h02;
  localparam logic [7:0] FAULT_PKT_SEQUENCE = 8'h03;
  localparam logic [7:0] FAULT_FOREIGN_OBJ  = 8'h05;
  localparam logic [7:0] FAULT_LIMIT        = 8'h06;
  localparam logic [7:0] FAULT_END_POWER    = 8'h08;

  // Fault parameter reasons
  localparam logic [7:0] REASON_CHARGE_DONE = 8'h01;
  localparam logic [7:0] REASON_OVER_TEMP   = 8'h03;
  localparam logic [7:0] REASON_OVER_VOLT   = 8'h04;
  localparam logic [7:0] REASON_OVER_CURR   = 8'h05;
  localparam logic [7:0] REASON_NO_RESPONSE = 8'h08;
  localparam logic [7:0] REASON_BATT_FULL   = 8'h10;
  localparam logic [7:0] REASON_NO_LOAD     = 8'h11;
  localparam logic [7:0] REASON_COMM_ERROR  = 8'h1B;

  // Values from the measurement logic, each with a load pulse
  typedef struct packed {
    logic [15:0] bridgePower;
    logic        bridgeValid;
    logic [15:0] fieldPower;
    logic        fieldValid;
    logic [15:0] rxPower;
    logic        rxValid;
    logic [7:0]  battery;
    logic        batteryValid;
    logic [3:0]  indicator;
    logic        indicatorValid;
    logic [7:0]  faultCode;
    logic [7:0]  faultParameter;
    logic        faultValid;
  } telemetry_s;

  // Levels from the status registers held elsewhere
  typedef struct packed {
    logic       sendOk;
    logic       apiSendOk;
    logic [5:0] rxGroup;
    logic [1:0] faultGroup;
    logic [1:0] diagGroup;
  } status_s;

endpackage : charger_telemetry_pkg

// *** tb/charger_telemetry_irq_masks_bench.sv ***
`timescale 1ns/1ps
`default_nettype none

module charger_telemetry_irq_masks_bench;
  logic                              core_clk = 1'b0;
  logic                              rst_n;
  logic [7:0]                        regAddr, regWrData, regRdData;
  logic                              regWrite, regRead, hostIrq;
  logic                              readPend = 1'b0;  // Read data due now
  logic [3:1]                        summaryFlags;
  charger_telemetry_pkg::telemetry_s telemetry;
  charger_telemetry_pkg::status_s    statusIn;
  int                                fails = 0, checks = 0;
  logic [15:0]                       bp, fp, rp;  // Last loaded powers
  logic [7:0]                        bt;
  // Fault codes and reasons, indexed by the load round
  localparam logic [7:0] FC [7] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h05, 8'h06, 8'h08};
  localparam logic [7:0] RS [8] = '{8'h01, 8'h03, 8'h04, 8'h05, 8'h08, 8'h10, 8'h11, 8'h1B};
  localparam logic [7:0] WM [4] = '{8'h3E, 8'h3F, 8'h03, 8'h03};  // Writable enable bits

  always #5 core_clk = ~core_clk;

  charger_telemetry_irq_masks u_charger_telemetry_irq_masks (
    .core_clk, .rst_n, .regAddr, .regWrData, .regWrite, .regRead,
    .regRdData, .telemetry, .statusIn, .summaryFlags, .hostIrq
  );

  host_bus_model u_host_bus_model (
    .core_clk, .regAddr, .regWrData, .regWrite, .regRead
  );

  // Compare and count; four-state equality so unknowns fail
  task automatic check(input logic [7:0] got, input logic [7:0] want, input string what);
    checks++;
    if (got !== want) begin
      fails++;
      $display("MISMATCH %0t %s got %h want %h", $time, what, got, want);
    end
  endtask : check

  // Read data stands one cycle after the strobe, zero otherwise
  always @(posedge core_clk) readPend <= regRead;
  always @(negedge core_clk) begin
    if (readPend)
      check(regRdData, u_host_bus_model.expQ.pop_front(), "read data");
    else
      check(regRdData, 8'h00, "idle read data");
  end

  // Drive one status cause up or down, off the host's idle edge
  task automatic cause(input int b, input logic v);
    u_host_bus_model.idle(1);
    case (b)
      5: statusIn.sendOk <= v;
      4: statusIn.apiSendOk <= v;
      3: statusIn.diagGroup <= {2{v}};
      2: statusIn.faultGroup <= {2{v}};
      default: statusIn.rxGroup <= {6{v}};
    endcase
  endtask : cause

  // Summary flags and interrupt, one cycle after the cause
  task automatic lvl(input logic [3:1] f, input logic i);
    u_host_bus_model.idle(1);
    @(negedge core_clk);
    check({4'h0, summaryFlags, hostIrq}, {4'h0, f, i}, "flags and irq");
  endtask : lvl

  // Load one set of measurements, drop the valids, read every byte back
  task automatic tele(input int i);
    bp = 16'($urandom);
    fp = 16'($urandom);
    rp = 16'($urandom);
    bt = 8'($urandom);
    u_host_bus_model.idle(1);
    telemetry <= '{bp, 1'b1, fp, 1'b1, rp, 1'b1, bt, 1'b1, 4'(i % 7), 1'b1, FC[i % 7], RS[i], 1'b1};
    u_host_bus_model.idle(1);
    telemetry <= '0;  // Values must hold once the valids drop
    u_host_bus_model.rd(8'h56, bp[7:0]);
    u_host_bus_model.rd(8'h57, bp[15:8]);
    u_host_bus_model.rd(8'h58, fp[7:0]);
    u_host_bus_model.rd(8'h59, fp[15:8]);
    u_host_bus_model.rd(8'h5A, rp[7:0]);
    u_host_bus_model.rd(8'h5B, rp[15:8]);
    u_host_bus_model.rd(8'h5C, bt);
    u_host_bus_model.rd(8'h5D, {4'h0, 4'(i % 7)});
    u_host_bus_model.rd(8'h5E, FC[i % 7]);
    u_host_bus_model.rd(8'h5F, RS[i]);
  endtask : tele

  // Verdict and end of run
  task automatic final_report;
    if (fails == 0 && checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : final_report

  // Hang guard, far beyond the few hundred cycles the tests need
  initial begin
    #200000;
    fails++;
    final_report();
  end

  // Main sequence
  initial begin
    rst_n     <= 1'b0;
    telemetry <= '0;
    statusIn  <= '0;
    void'($urandom(32'hE2358297));
    repeat (12) @(posedge core_clk);
    rst_n <= 1'b1;
    // Whole map reads zero after reset, unmapped places included
    for (int a = 'h56; a <= 'h7C; a++) u_host_bus_model.rd(8'(a), 8'h00);
    u_host_bus_model.rd(8'hFF, 8'h00);
    for (int i = 0; i < 8; i++) tele(i);
    // Read-only place ignores a write
    u_host_bus_model.wr(8'h5C, 8'hFF);
    u_host_bus_model.rd(8'h5C, bt);
    // Enables: reserved bits read back zero
    for (int i = 0; i < 4; i++) begin
      u_host_bus_model.wr(8'(8'h78 + i), 8'hFF);
      u_host_bus_model.rd(8'(8'h78 + i), WM[i]);
    end
    // Each event source, enabled alone: rise interrupts, clear drops it
    for (int b = 5; b >= 1; b--) begin
      u_host_bus_model.wr(8'h78, 8'(1 << b));
      cause(b, 1'b1);
      lvl((b <= 3) ? 3'(1 << (b - 1)) : 3'b000, 1'b1);
      u_host_bus_model.rd(8'h7C, 8'(1 << b));
      u_host_bus_model.wr(8'h7C, 8'(1 << b));
      lvl((b <= 3) ? 3'(1 << (b - 1)) : 3'b000, 1'b0);
      cause(b, 1'b0);
    end
    // Masked rise is recorded but silent until enabled
    u_host_bus_model.wr(8'h78, 8'h00);
    cause(5, 1'b1);
    lvl(3'b000, 1'b0);
    u_host_bus_model.rd(8'h7C, 8'h20);
    u_host_bus_model.wr(8'h78, 8'h20);
    u_host_bus_model.idle(1);  // Enable reaches the line a cycle later
    lvl(3'b000, 1'b1);
    u_host_bus_model.wr(8'h7C, 8'h20);
    cause(5, 1'b0);
    // Group enables gate the receiver and fault summary flags bit by bit
    u_host_bus_model.wr(8'h79, 8'h01);
    u_host_bus_model.wr(8'h7A, 8'h02);
    u_host_bus_model.wr(8'h78, 8'h06);
    u_host_bus_model.idle(1);
    statusIn.rxGroup <= 6'h3E;
    statusIn.faultGroup <= 2'b01;
    lvl(3'b000, 1'b0);
    u_host_bus_model.idle(1);
    statusIn.rxGroup <= 6'h01;
    statusIn.faultGroup <= 2'b10;
    lvl(3'b011, 1'b1);
    u_host_bus_model.idle(3);
    final_report();
  end
endmodule : charger_telemetry_irq_masks_bench

`default_nettype wire

// *** tb/host_bus_model.sv ***
`timescale 1ns/1ps
`default_nettype none

// Host side of the register port: one access per rising edge, no wait states
module host_bus_model (
  input  wire logic       core_clk,
  output var  logic [7:0] regAddr,
  output var  logic [7:0] regWrData,
  output var  logic       regWrite,
  output var  logic       regRead
);
  logic [7:0] expQ[$];  // Expected read bytes, oldest first

  // Quiet bus at time zero
  initial begin
    regAddr   = 8'h00;
    regWrData = 8'h00;
    regWrite  = 1'b0;
    regRead   = 1'b0;
  end

  // Write strobe for one cycle; read is dropped in the same step
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    regAddr   <= a;
    regWrData <= d;
    regWrite  <= 1'b1;
    regRead   <= 1'b0;
  endtask : wr

  // Read strobe; the expected byte is noted for the compare process
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge core_clk);
    regAddr  <= a;
    regRead  <= 1'b1;
    regWrite <= 1'b0;
    expQ.push_back(e);
  endtask : rd

  // Idle cycles; released lines toggle so a stale value never looks valid
  task automatic idle(input int n);
    repeat (n) begin
      @(posedge core_clk);
      regWrite  <= 1'b0;
      regRead   <= 1'b0;
      regAddr   <= ~regAddr;
      regWrData <= ~regWrData;
    end
  endtask : idle
endmodule : host_bus_model

`default_nettype wire
